// ==== rtl/rtcc_map.svh ====
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH
// ********************************
// register locations
// ********************************
`define RTCC_A_SEC       3'h0
`define RTCC_A_MIN       3'h1
`define RTCC_A_HOUR      3'h2
`define RTCC_A_DAY       3'h3
`define RTCC_A_DATE      3'h4
`define RTCC_A_MONTH     3'h5
`define RTCC_A_YEAR      3'h6
`define RTCC_A_CAL       3'h7
`define RTCC_NREGS       8
// ********************************
// link and time base
// ********************************
`define RTCC_SLAVE_ADDR  7'h68
`define RTCC_OSC_HZ      32768
`define RTCC_BITS        4'h8
// ********************************
// bcd limits and field positions
// ********************************
`define RTCC_MAX_SEC     8'h59
`define RTCC_MAX_HOUR    8'h23
`define RTCC_MAX_DAY     8'h07
`define RTCC_MAX_MONTH   8'h12
`define RTCC_MAX_YEAR    8'h99
`define RTCC_ZERO        8'h00
`define RTCC_ONE         8'h01
`define RTCC_FEB         8'h02
`define RTCC_CENT_EN_BIT 7
`define RTCC_CENT_BIT    6
`define RTCC_RESET_DATE  8'h01
`endif

// ==== rtl/rtcc_pkg.sv ====
package rtcc_pkg;
   typedef logic [7:0] rtcc_byte_t;
   typedef logic [7:0][7:0] rtcc_regs_t;
   typedef struct packed {
      logic       en;
      logic [2:0] addr;
      logic [7:0] data;
   } rtcc_wr_s;
   typedef enum logic [3:0] {
      RTCC_IDLE, RTCC_ADDR, RTCC_ACK_ADDR, RTCC_WORD, RTCC_ACK_WORD,
      RTCC_WR_DATA, RTCC_ACK_WR, RTCC_RD_DATA, RTCC_RD_ACK
   } rtcc_state_e;
endpackage

// ==== rtl/rtcc_calendar.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_map.svh"
module rtcc_calendar (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              tick,
   input  wire rtcc_pkg::rtcc_wr_s wr,
   output var  rtcc_pkg::rtcc_regs_t regs
);
   // ********************************
   // bcd helpers
   // ********************************
   // returns {carry, next}; wraps from top to bottom value
   function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
                                           input logic [7:0] bottom);
      if (v >= top) begin
         bcd_step = {1'b1, bottom};
      end else if (v[3:0] == 4'h9) begin
         bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_step = {1'b0, v + 8'h01};
      end
   endfunction

   // year 00 counts as leap, which holds up to 2100
   function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
      logic [1:0] m4;
      m4 = 2'(yr[0] + {yr[4], 1'b0});
      m4 = 2'(m4 + {1'b0, yr[1]} * 2'h2);
      if (mon == `RTCC_FEB) begin
         month_len = (m4 == 2'h0) ? 8'h29 : 8'h28;
      end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
         month_len = 8'h30;
      end else begin
         month_len = 8'h31;
      end
   endfunction

   logic [8:0] s_n, m_n, h_n, d_n, dt_n, mo_n, y_n;
   always_comb begin
      // flag bits above each field are kept out of the count
      s_n  = bcd_step({1'h0, regs[`RTCC_A_SEC][6:0]}, `RTCC_MAX_SEC, `RTCC_ZERO);
      m_n  = bcd_step({1'h0, regs[`RTCC_A_MIN][6:0]}, `RTCC_MAX_SEC, `RTCC_ZERO);
      h_n  = bcd_step({2'h0, regs[`RTCC_A_HOUR][5:0]}, `RTCC_MAX_HOUR, `RTCC_ZERO);
      d_n  = bcd_step(regs[`RTCC_A_DAY], `RTCC_MAX_DAY, `RTCC_ONE);
      dt_n = bcd_step(regs[`RTCC_A_DATE],
                      month_len(regs[`RTCC_A_MONTH], regs[`RTCC_A_YEAR]), `RTCC_ONE);
      mo_n = bcd_step(regs[`RTCC_A_MONTH], `RTCC_MAX_MONTH, `RTCC_ONE);
      y_n  = bcd_step(regs[`RTCC_A_YEAR], `RTCC_MAX_YEAR, `RTCC_ZERO);
   end

   // ********************************
   // counters
   // ********************************
   // a write takes the whole register file for that cycle, so a tick that
   // collides with a write is dropped rather than half-applied
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regs              <= '0;
         regs[`RTCC_A_DAY]  <= `RTCC_RESET_DATE;
         regs[`RTCC_A_DATE] <= `RTCC_RESET_DATE;
         regs[`RTCC_A_MONTH] <= `RTCC_RESET_DATE;
      end else if (wr.en) begin
         regs[wr.addr] <= wr.data;
      end else if (tick) begin
         regs[`RTCC_A_SEC] <= {regs[`RTCC_A_SEC][7], s_n[6:0]};
         if (s_n[8]) begin
            regs[`RTCC_A_MIN] <= {regs[`RTCC_A_MIN][7], m_n[6:0]};
            if (m_n[8]) begin
               regs[`RTCC_A_HOUR][5:0] <= h_n[5:0];
               if (h_n[8]) begin
                  regs[`RTCC_A_DAY]  <= d_n[7:0];
                  regs[`RTCC_A_DATE] <= dt_n[7:0];
                  if (dt_n[8]) begin
                     regs[`RTCC_A_MONTH] <= mo_n[7:0];
                     if (mo_n[8]) begin
                        regs[`RTCC_A_YEAR] <= y_n[7:0];
                        if (y_n[8] && regs[`RTCC_A_HOUR][`RTCC_CENT_EN_BIT]) begin
                           regs[`RTCC_A_HOUR][`RTCC_CENT_BIT] <=
                              ~regs[`RTCC_A_HOUR][`RTCC_CENT_BIT];
                        end
                     end
                  end
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/rtcc_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_map.svh"
module rtcc_top (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic osc_32k,
   input  wire logic scl,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe
);
   // ********************************
   // pin synchronisers
   // ********************************
   logic [1:0] scl_sync, sda_sync, osc_sync;
   logic       scl_d, sda_d, osc_d;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         osc_sync <= 2'h0;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
         osc_d    <= 1'b0;
      end else begin
         scl_sync <= {scl_sync[0], scl};
         sda_sync <= {sda_sync[0], sda_in};
         osc_sync <= {osc_sync[0], osc_32k};
         scl_d    <= scl_sync[1];
         sda_d    <= sda_sync[1];
         osc_d    <= osc_sync[1];
      end
   end
   logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c, osc_rise;
   assign scl_s    = scl_sync[1];
   assign sda_s    = sda_sync[1];
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;
   assign osc_rise = osc_sync[1] & ~osc_d;

   // ********************************
   // one-second time base
   // ********************************
   localparam int unsigned DIV_W = $clog2(`RTCC_OSC_HZ);
   logic [DIV_W-1:0] div_reg;
   logic             tick_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= 1'b0;
         if (osc_rise) begin
            if (div_reg == DIV_W'(`RTCC_OSC_HZ - 1)) begin
               div_reg  <= '0;
               tick_reg <= 1'b1;
            end else begin
               div_reg <= div_reg + 1'b1;
            end
         end
      end
   end

   // ********************************
   // counters and user copy
   // ********************************
   rtcc_pkg::rtcc_wr_s   wr_reg;
   rtcc_pkg::rtcc_regs_t run_regs, user_reg;
   rtcc_calendar rtcc_calendar_i (
      .clk   (clk),
      .reset (reset),
      .tick  (tick_reg),
      .wr    (wr_reg),
      .regs  (run_regs)
   );

   rtcc_pkg::rtcc_state_e state_reg;
   logic [2:0]            ptr_reg;
   logic                  frozen;
   // while a clock location is addressed the snapshot holds still so a multi
   // byte read cannot see a carry ripple between bytes
   assign frozen = (state_reg != rtcc_pkg::RTCC_IDLE) && (ptr_reg != `RTCC_A_CAL);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         user_reg <= '0;
      end else if (!frozen) begin
         user_reg <= run_regs;
      end
   end

   // ********************************
   // serial slave
   // ********************************
   logic [7:0] shift_reg;
   logic [3:0] cnt_reg;
   logic       rw_reg;
   logic       acked_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= rtcc_pkg::RTCC_IDLE;
         shift_reg <= '0;
         cnt_reg   <= '0;
         rw_reg    <= 1'b0;
         acked_reg <= 1'b0;
         ptr_reg   <= `RTCC_A_SEC;
         wr_reg    <= '0;
         sda_oe    <= 1'b0;
      end else begin
         wr_reg.en <= 1'b0;
         if (stop_c) begin
            state_reg <= rtcc_pkg::RTCC_IDLE;
            sda_oe    <= 1'b0;
         end else if (start_c) begin
            state_reg <= rtcc_pkg::RTCC_ADDR;
            cnt_reg   <= '0;
            sda_oe    <= 1'b0;
         end else begin
            unique case (state_reg)
               rtcc_pkg::RTCC_IDLE: begin
               end
               rtcc_pkg::RTCC_ADDR, rtcc_pkg::RTCC_WORD, rtcc_pkg::RTCC_WR_DATA: begin
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], sda_s};
                     cnt_reg   <= cnt_reg + 4'h1;
                  end else if (scl_fall && cnt_reg == `RTCC_BITS) begin
                     cnt_reg <= '0;
                     if (state_reg == rtcc_pkg::RTCC_ADDR) begin
                        if (shift_reg[7:1] == `RTCC_SLAVE_ADDR) begin
                           rw_reg    <= shift_reg[0];
                           sda_oe    <= 1'b1;
                           state_reg <= rtcc_pkg::RTCC_ACK_ADDR;
                        end else begin
                           state_reg <= rtcc_pkg::RTCC_IDLE;
                        end
                     end else if (state_reg == rtcc_pkg::RTCC_WORD) begin
                        ptr_reg   <= shift_reg[2:0];
                        sda_oe    <= 1'b1;
                        state_reg <= rtcc_pkg::RTCC_ACK_WORD;
                     end else begin
                        wr_reg    <= '{en: 1'b1, addr: ptr_reg, data: shift_reg};
                        sda_oe    <= 1'b1;
                        state_reg <= rtcc_pkg::RTCC_ACK_WR;
                     end
                  end
               end
               rtcc_pkg::RTCC_ACK_ADDR: begin
                  if (scl_fall) begin
                     if (rw_reg) begin
                        // a read without a word address starts at the kept pointer
                        shift_reg <= {user_reg[ptr_reg][6:0], 1'b0};
                        sda_oe    <= ~user_reg[ptr_reg][7];
                        cnt_reg   <= 4'h1;
                        state_reg <= rtcc_pkg::RTCC_RD_DATA;
                     end else begin
                        sda_oe    <= 1'b0;
                        state_reg <= rtcc_pkg::RTCC_WORD;
                     end
                  end
               end
               rtcc_pkg::RTCC_ACK_WORD: begin
                  if (scl_fall) begin
                     sda_oe    <= 1'b0;
                     state_reg <= rtcc_pkg::RTCC_WR_DATA;
                  end
               end
               rtcc_pkg::RTCC_ACK_WR: begin
                  if (scl_fall) begin
                     sda_oe    <= 1'b0;
                     ptr_reg   <= ptr_reg + 3'h1;
                     state_reg <= rtcc_pkg::RTCC_WR_DATA;
                  end
               end
               rtcc_pkg::RTCC_RD_DATA: begin
                  if (scl_fall) begin
                     if (cnt_reg == `RTCC_BITS) begin
                        sda_oe    <= 1'b0;
                        state_reg <= rtcc_pkg::RTCC_RD_ACK;
                     end else begin
                        sda_oe    <= ~shift_reg[7];
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        cnt_reg   <= cnt_reg + 4'h1;
                     end
                  end
               end
               rtcc_pkg::RTCC_RD_ACK: begin
                  if (scl_rise) begin
                     acked_reg <= ~sda_s;
                     ptr_reg   <= ptr_reg + 3'h1;
                  end else if (scl_fall) begin
                     if (acked_reg) begin
                        shift_reg <= {user_reg[ptr_reg][6:0], 1'b0};
                        sda_oe    <= ~user_reg[ptr_reg][7];
                        cnt_reg   <= 4'h1;
                        state_reg <= rtcc_pkg::RTCC_RD_DATA;
                     end else begin
                        // master ended the read: leave the line high for its stop
                        state_reg <= rtcc_pkg::RTCC_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // open drain: only ever pulls low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== bench/rtcc_top_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtcc_top_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic osc_32k,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe
);
   logic       scl_q;
   logic       sda_q;
   logic [3:0] falls;
   logic [7:0] shift;
   wire        fall_ev  = scl_q && !scl;
   wire        start_ev = scl && scl_q && sda_q && !sda_in;
   wire        stop_ev  = scl && scl_q && !sda_q && sda_in;
   wire        ack_ev   = fall_ev && falls == 4'h8;
   // ****************************************
   // bus tracking seen from the pins
   // ****************************************
   // the first fall after a start ends the start itself, so the ninth fall opens the ack
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         falls <= 4'hf;
         shift <= 8'h00;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
         if (start_ev) begin
            falls <= 4'h0;
         end else if (fall_ev && falls != 4'hf) begin
            falls <= falls + 4'h1;
         end
         if (scl && !scl_q) begin
            shift <= {shift[6:0], sda_in};
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   AST_OPEN_DRAIN: assert property (!sda_out)
      else $error("data pin driven high");
   AST_ADDR_ACK: assert property (ack_ev && shift[7:1] == 7'h68 |-> ##[1:6] sda_oe)
      else $error("own address not acknowledged");
   AST_ADDR_NACK: assert property (ack_ev && shift[7:1] != 7'h68 |-> !sda_oe[*8])
      else $error("foreign address acknowledged");
   AST_START_FREE: assert property (start_ev |-> ##4 !sda_oe[*4])
      else $error("data line held after start");
   AST_STOP_FREE: assert property (stop_ev && !sda_oe |=> !sda_oe[*8])
      else $error("data line taken after stop");
   AST_DRIVE_IN_LOW: assert property ($rose(sda_oe) |-> !scl && !$past(scl, 2))
      else $error("drive began outside clock low");
   AST_STABLE_HIGH: assert property ($rose(scl) |=> $stable(sda_oe)[*6])
      else $error("data changed while clock high");
   AST_DRIVE_STANDS: assert property ($rose(sda_oe) |-> sda_oe throughout (##[1:40] $rose(scl)))
      else $error("drive dropped before clock high");
endmodule
`default_nettype wire

// ==== bench/rtcc_master.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtcc_master #(
   parameter int Q = 10
) (
   input  wire logic clk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_oe
);
   // clock rests high between frames; data is only ever pulled low, never driven high
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic wait_q();
      repeat (Q) @(negedge clk);
   endtask
   // also serves as repeated start from clock low
   task automatic start();
      sda_oe = 1'b0;
      wait_q();
      scl = 1'b1;
      wait_q();
      sda_oe = 1'b1;
      wait_q();
      scl = 1'b0;
      wait_q();
   endtask
   task automatic xbit(input logic b, output logic r);
      sda_oe = !b;
      wait_q();
      scl = 1'b1;
      wait_q();
      r = sda;
      wait_q();
      scl = 1'b0;
      wait_q();
   endtask
   task automatic xbyte(input logic [7:0] d, input logic ack, output logic [7:0] r,
                        output logic a);
      for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
      xbit(ack, a);
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      wait_q();
      scl = 1'b1;
      wait_q();
      sda_oe = 1'b0;
      wait_q();
   endtask
endmodule
`default_nettype wire

// ==== bench/rtcc_top_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtcc_top_bench;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       osc_32k = 1'b0;
   logic       osc_run = 1'b0;
   logic       scl;
   logic       m_oe;
   logic       sda_out;
   logic       sda_oe;
   logic [7:0] r;
   logic       a;
   int         errors = 0;
   int         checked = 0;
   wire        sda = !(m_oe || sda_oe);
   logic [7:0] tv [8] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h01, 8'h5a};
   logic [7:0] nx [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h01, 8'h5a};
   rtcc_top rtcc_top_i (.clk(clk), .reset(reset), .osc_32k(osc_32k), .scl(scl),
                        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   rtcc_master rtcc_master_i (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
   always #2 clk = !clk;
   // crystal sped up to one clk per half period so a tick fits in the run
   always @(negedge clk) if (osc_run) osc_32k <= !osc_32k;
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_ack(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic send(input logic [7:0] d, input logic exp_ack);
      rtcc_master_i.xbyte(d, 1'b1, r, a);
      chk_ack(a, exp_ack);
   endtask
   task automatic read8(input logic [7:0] exp [8]);
      for (int i = 0; i < 8; i++) begin
         rtcc_master_i.xbyte(8'hff, i == 7, r, a);
         chk_byte(r, exp[i]);
      end
      rtcc_master_i.stop();
   endtask
   task automatic t_bad_addr();
      logic [7:0] bad [3] = '{8'hd2, 8'h50, 8'hd8};
      foreach (bad[i]) begin
         rtcc_master_i.start();
         send(bad[i], 1'b1);
         rtcc_master_i.stop();
      end
      $display("test bad_addr done");
   endtask
   task automatic t_write();
      rtcc_master_i.start();
      send(8'hd0, 1'b0);
      send(8'h00, 1'b0);
      foreach (tv[i]) send(tv[i], 1'b0);
      rtcc_master_i.stop();
      $display("test write done");
   endtask
   // the tick lands while the pointer sits on seconds, so reads must show old time
   task automatic t_frozen();
      rtcc_master_i.start();
      send(8'hd0, 1'b0);
      send(8'h00, 1'b0);
      osc_run = 1'b1;
      repeat (65536 + 64) @(negedge clk);
      osc_run = 1'b0;
      rtcc_master_i.start();
      send(8'hd1, 1'b0);
      read8(tv);
      $display("test frozen done");
   endtask
   // no word address: the pointer must have wrapped back to seconds
   task automatic t_wrap();
      rtcc_master_i.start();
      send(8'hd1, 1'b0);
      read8(nx);
      $display("test wrap done");
   endtask
   // a reset in mid-run must bring back the power-up time and a pointer on seconds
   task automatic t_reset();
      logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      rtcc_master_i.start();
      send(8'hd1, 1'b0);
      read8(rv);
      $display("test reset done");
   endtask
   task automatic finish_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      t_bad_addr();
      t_write();
      t_frozen();
      t_wrap();
      t_reset();
      finish_test();
   end
   // about 81k cycles expected; cut off well past that
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
endmodule
bind rtcc_top rtcc_top_sva rtcc_top_sva_i (.clk(clk), .reset(reset), .osc_32k(osc_32k),
   .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire
